// File: ubt_regs.vh
// Register offsets, field positions and reset values of the user break unit.
`ifndef UBT_REGS_VH
`define UBT_REGS_VH

`define UBT_OFS_ADDR_A   8'h00
`define UBT_OFS_AMASK_A  8'h04
`define UBT_OFS_CYCLE_A  8'h08
`define UBT_OFS_ADDR_B   8'h0c
`define UBT_OFS_AMASK_B  8'h10
`define UBT_OFS_CYCLE_B  8'h14
`define UBT_OFS_DATA_B   8'h18
`define UBT_OFS_DMASK_B  8'h1c
`define UBT_OFS_CTRL     8'h20
`define UBT_OFS_COUNT    8'h24
`define UBT_OFS_TRC_SRC  8'h28
`define UBT_OFS_TRC_DST  8'h2c

`define UBT_CTL_CNT_EN   0
`define UBT_CTL_SEQ      1
`define UBT_CTL_TRACE    2
`define UBT_CTL_AFTER_A  3
`define UBT_CTL_AFTER_B  4
`define UBT_CTL_DATA_B   5
`define UBT_CTL_W        6
`define UBT_FLAG_LSB     8
`define UBT_FLAG_W       4

`define UBT_CS_BUS_L     0
`define UBT_CS_BUS_I     1
`define UBT_CS_FETCH     2
`define UBT_CS_DATA      3
`define UBT_CS_READ      4
`define UBT_CS_WRITE     5
`define UBT_CS_SIZE_LSB  6
`define UBT_CS_W         8

`define UBT_SZ_BYTE      2'h0
`define UBT_SZ_WORD      2'h1
`define UBT_SZ_LONG      2'h2

`define UBT_CNT_W        16
`define UBT_TRC_AW       28
`define UBT_TRC_DEPTH    4

`define UBT_RST_CYCLE    8'h00
`define UBT_RST_CTRL     6'h00
`define UBT_RST_COUNT    16'h0000

`endif

// File: ubt_chan_cmp.v
// Bus cycle comparator of one break channel.
`include "ubt_regs.vh"

module ubt_chan_cmp (
  // Condition
  input  wire [31:0]           addr_cond_i,
  input  wire [31:0]           addr_mask_i,
  input  wire [`UBT_CS_W-1:0]  cycle_sel_i,
  input  wire [31:0]           data_cond_i,
  input  wire [31:0]           data_mask_i,
  input  wire                  data_en_i,
  // Local bus
  input  wire                  lbus_valid_i,
  input  wire [31:0]           lbus_addr_i,
  input  wire                  lbus_fetch_i,
  input  wire                  lbus_write_i,
  input  wire [1:0]            lbus_size_i,
  input  wire [31:0]           lbus_data_i,
  // Internal bus
  input  wire                  ibus_valid_i,
  input  wire [31:0]           ibus_addr_i,
  input  wire                  ibus_fetch_i,
  input  wire                  ibus_write_i,
  input  wire [1:0]            ibus_size_i,
  input  wire [31:0]           ibus_data_i,
  // Result
  output wire                  hit_o,
  output wire                  hit_fetch_o,
  output wire                  hit_ibus_o,
  output wire [31:0]           hit_addr_o
);

  wire use_l = cycle_sel_i[`UBT_CS_BUS_L] & ~cycle_sel_i[`UBT_CS_BUS_I];
  wire use_i = cycle_sel_i[`UBT_CS_BUS_I] & ~cycle_sel_i[`UBT_CS_BUS_L];

  wire        valid = (use_l & lbus_valid_i) | (use_i & ibus_valid_i);
  wire [31:0] addr  = use_i ? ibus_addr_i  : lbus_addr_i;
  wire        fetch = use_i ? ibus_fetch_i : lbus_fetch_i;
  wire        wr    = use_i ? ibus_write_i : lbus_write_i;
  wire [1:0]  size  = use_i ? ibus_size_i  : lbus_size_i;
  wire [31:0] data  = use_i ? ibus_data_i  : lbus_data_i;

  wire kind_ok = fetch ? cycle_sel_i[`UBT_CS_FETCH] : cycle_sel_i[`UBT_CS_DATA];
  wire rw_ok = wr ? cycle_sel_i[`UBT_CS_WRITE] : cycle_sel_i[`UBT_CS_READ];
  wire odd_fetch = fetch & addr_cond_i[0];

  wire [1:0] cs_size = cycle_sel_i[`UBT_CS_SIZE_LSB+1:`UBT_CS_SIZE_LSB];
  wire size_ok = (cs_size == 2'h0) | (cs_size == (size + 2'h1));

  // Low address bits below the access size take no part in the compare.
  wire [31:0] low_ign = (size == `UBT_SZ_LONG) ? 32'h00000003 :
                        (size == `UBT_SZ_WORD) ? 32'h00000001 : 32'h00000000;
  wire addr_ok = ((addr ^ addr_cond_i) & ~(addr_mask_i | low_ign)) == 32'h00000000;

  wire [31:0] dwin = (size == `UBT_SZ_LONG) ? 32'hffffffff :
                     (size == `UBT_SZ_WORD) ? 32'h0000ffff : 32'h000000ff;
  wire data_ok = ~data_en_i | fetch |
                 (((data ^ data_cond_i) & ~data_mask_i & dwin) == 32'h00000000);

  assign hit_o       = valid & kind_ok & rw_ok & ~odd_fetch & size_ok & addr_ok & data_ok;
  assign hit_fetch_o = fetch;
  assign hit_ibus_o  = use_i;
  assign hit_addr_o  = addr;

endmodule // ubt_chan_cmp

// File: ubt_trace_q.v
// Four-deep branch trace queue of source and destination pairs.
`include "ubt_regs.vh"

module ubt_trace_q (
  // Clock and reset
  input  wire                   clk_i,
  input  wire                   sys_rst_i,
  // Control
  input  wire                   clr_i,
  input  wire                   push_i,
  input  wire [`UBT_TRC_AW-1:0] src_i,
  input  wire [`UBT_TRC_AW-1:0] dst_i,
  input  wire                   pop_i,
  // Head of queue
  output wire [`UBT_TRC_AW-1:0] src_o,
  output wire [`UBT_TRC_AW-1:0] dst_o
);

  reg [`UBT_TRC_AW-1:0] src_mem [0:`UBT_TRC_DEPTH-1];
  reg [`UBT_TRC_AW-1:0] dst_mem [0:`UBT_TRC_DEPTH-1];
  reg [1:0]             wr_reg;
  reg [1:0]             rd_reg;
  reg [2:0]             cnt_reg;

  wire full  = (cnt_reg == 3'h4);
  wire empty = (cnt_reg == 3'h0);
  wire do_pop = pop_i & ~empty;
  // A full queue keeps the newest branches and drops the oldest one.
  wire drop = push_i & full;

  assign src_o = empty ? {`UBT_TRC_AW{1'b0}} : src_mem[rd_reg];
  assign dst_o = empty ? {`UBT_TRC_AW{1'b0}} : dst_mem[rd_reg];

  always @(posedge clk_i) begin
    if (push_i) begin
      src_mem[wr_reg] <= src_i;
      dst_mem[wr_reg] <= dst_i;
    end
  end

  always @(posedge clk_i) begin
    if (sys_rst_i | clr_i) begin
      wr_reg  <= 2'h0;
      rd_reg  <= 2'h0;
      cnt_reg <= 3'h0;
    end else begin
      if (push_i)
        wr_reg <= wr_reg + 2'h1;
      if (do_pop | drop)
        rd_reg <= rd_reg + 2'h1;
      if (push_i & ~do_pop & ~full)
        cnt_reg <= cnt_reg + 3'h1;
      else if (do_pop & ~push_i)
        cnt_reg <= cnt_reg - 3'h1;
    end
  end

endmodule // ubt_trace_q

// File: ubt_break.v
// User break unit: two bus channels, break request, flags and branch trace.
`include "ubt_regs.vh"

module ubt_break (
  // Clock and reset
  input  wire        clk_i,
  input  wire        sys_rst_i,
  // Register port
  input  wire [7:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_we_i,
  input  wire        reg_re_i,
  output reg  [31:0] reg_rdata_o,
  // Local bus monitor
  input  wire        lbus_valid_i,
  input  wire [31:0] lbus_addr_i,
  input  wire        lbus_fetch_i,
  input  wire        lbus_write_i,
  input  wire [1:0]  lbus_size_i,
  input  wire [31:0] lbus_data_i,
  // Internal bus monitor
  input  wire        ibus_valid_i,
  input  wire [31:0] ibus_addr_i,
  input  wire        ibus_fetch_i,
  input  wire        ibus_write_i,
  input  wire [1:0]  ibus_size_i,
  input  wire [31:0] ibus_data_i,
  // Pipeline progress
  input  wire        cpu_issue_i,
  input  wire [31:0] cpu_issue_pc_i,
  input  wire        cpu_done_i,
  input  wire [31:0] cpu_next_pc_i,
  input  wire        cpu_reexec_exc_i,
  input  wire        cpu_trap_exc_i,
  input  wire        cpu_addr_err_i,
  // Branch trace events
  input  wire        cpu_br_i,
  input  wire [31:0] cpu_br_pc_i,
  input  wire [31:0] cpu_br_dst_i,
  input  wire        cpu_exc_i,
  input  wire [31:0] cpu_exc_ret_i,
  input  wire [31:0] cpu_exc_vec_i,
  // Break request
  output reg         brk_req_o,
  output reg  [31:0] brk_pc_o
);

  reg [31:0]            addr_a_reg;
  reg [31:0]            amask_a_reg;
  reg [`UBT_CS_W-1:0]   cycle_a_reg;
  reg [31:0]            addr_b_reg;
  reg [31:0]            amask_b_reg;
  reg [`UBT_CS_W-1:0]   cycle_b_reg;
  reg [31:0]            data_b_reg;
  reg [31:0]            dmask_b_reg;
  reg [`UBT_CTL_W-1:0]  ctl_reg;
  reg [`UBT_FLAG_W-1:0] flag_reg;
  reg [`UBT_FLAG_W-1:0] flag_next;
  reg [`UBT_CNT_W-1:0]  cnt_reg;
  reg                   seq_arm_reg;
  reg                   trace_q_reg;
  reg [31:0]            rdata_next;

  wire [1:0]  hit;
  wire [1:0]  hit_fetch;
  wire [1:0]  hit_ibus;
  wire [31:0] hit_addr_a;
  wire [31:0] hit_addr_b;
  wire [1:0]  after_sel;
  wire [1:0]  before_ev;
  wire [1:0]  flag_ev;
  wire [1:0]  cand;
  wire [1:0]  ev_ibus;

  wire [`UBT_TRC_AW-1:0] trc_src;
  wire [`UBT_TRC_AW-1:0] trc_dst;

  wire wr_ctrl = reg_we_i & (reg_addr_i == `UBT_OFS_CTRL);
  wire seq     = ctl_reg[`UBT_CTL_SEQ];
  wire cnt_en  = ctl_reg[`UBT_CTL_CNT_EN];
  wire te      = ctl_reg[`UBT_CTL_TRACE];

  assign after_sel = {ctl_reg[`UBT_CTL_AFTER_B], ctl_reg[`UBT_CTL_AFTER_A]};

  ubt_chan_cmp u_cmp_a (
    .addr_cond_i  (addr_a_reg),
    .addr_mask_i  (amask_a_reg),
    .cycle_sel_i  (cycle_a_reg),
    .data_cond_i  (32'h00000000),
    .data_mask_i  (32'hffffffff),
    .data_en_i    (1'b0),
    .lbus_valid_i (lbus_valid_i),
    .lbus_addr_i  (lbus_addr_i),
    .lbus_fetch_i (lbus_fetch_i),
    .lbus_write_i (lbus_write_i),
    .lbus_size_i  (lbus_size_i),
    .lbus_data_i  (lbus_data_i),
    .ibus_valid_i (ibus_valid_i),
    .ibus_addr_i  (ibus_addr_i),
    .ibus_fetch_i (ibus_fetch_i),
    .ibus_write_i (ibus_write_i),
    .ibus_size_i  (ibus_size_i),
    .ibus_data_i  (ibus_data_i),
    .hit_o        (hit[0]),
    .hit_fetch_o  (hit_fetch[0]),
    .hit_ibus_o   (hit_ibus[0]),
    .hit_addr_o   (hit_addr_a)
  );

  ubt_chan_cmp u_cmp_b (
    .addr_cond_i  (addr_b_reg),
    .addr_mask_i  (amask_b_reg),
    .cycle_sel_i  (cycle_b_reg),
    .data_cond_i  (data_b_reg),
    .data_mask_i  (dmask_b_reg),
    .data_en_i    (ctl_reg[`UBT_CTL_DATA_B]),
    .lbus_valid_i (lbus_valid_i),
    .lbus_addr_i  (lbus_addr_i),
    .lbus_fetch_i (lbus_fetch_i),
    .lbus_write_i (lbus_write_i),
    .lbus_size_i  (lbus_size_i),
    .lbus_data_i  (lbus_data_i),
    .ibus_valid_i (ibus_valid_i),
    .ibus_addr_i  (ibus_addr_i),
    .ibus_fetch_i (ibus_fetch_i),
    .ibus_write_i (ibus_write_i),
    .ibus_size_i  (ibus_size_i),
    .ibus_data_i  (ibus_data_i),
    .hit_o        (hit[1]),
    .hit_fetch_o  (hit_fetch[1]),
    .hit_ibus_o   (hit_ibus[1]),
    .hit_addr_o   (hit_addr_b)
  );

  // A fetch hit only arms the channel; the break is decided when the
  // pipeline issues that address (for an after break, when it completes), so discarded prefetches are left alone.
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      reg        arm_r;
      reg [31:0] fpc_r;
      reg        pend_r;
      reg        ibus_r;
      wire       iss_hit = cpu_issue_i & arm_r & (cpu_issue_pc_i == fpc_r);
      wire       done_ev = cpu_done_i & pend_r;
      wire       set_pend = (iss_hit & after_sel[ch]) | (hit[ch] & ~hit_fetch[ch]);

      assign before_ev[ch] = iss_hit & ~after_sel[ch];
      assign flag_ev[ch] = before_ev[ch] | (done_ev & ~cpu_reexec_exc_i);
      assign cand[ch] = before_ev[ch] |
                        (done_ev & ~cpu_reexec_exc_i & ~cpu_trap_exc_i & ~cpu_addr_err_i);
      assign ev_ibus[ch] = ibus_r;

      always @(posedge clk_i) begin
        if (sys_rst_i) begin
          arm_r  <= 1'b0;
          fpc_r  <= 32'h00000000;
          pend_r <= 1'b0;
          ibus_r <= 1'b0;
        end else begin
          if (hit[ch] & hit_fetch[ch]) begin
            arm_r  <= 1'b1;
            fpc_r  <= (ch == 0) ? hit_addr_a : hit_addr_b;
            ibus_r <= hit_ibus[ch];
          end else if (iss_hit) begin
            arm_r <= 1'b0;
          end
          if (hit[ch] & ~hit_fetch[ch])
            ibus_r <= hit_ibus[ch];
          if (set_pend)
            pend_r <= 1'b1;
          else if (cpu_done_i)
            pend_r <= 1'b0;
        end
      end
    end
  endgenerate

  wire fire_a = cand[0] & ~seq;
  wire b_ok   = cand[1] & (~seq | seq_arm_reg);
  wire cnt_last = (cnt_reg <= `UBT_CNT_W'h1);
  wire fire_b   = b_ok & (~cnt_en | cnt_last);
  wire pc_issue = (fire_a & before_ev[0]) | (fire_b & before_ev[1]);

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      seq_arm_reg <= 1'b0;
    end else if (~seq) begin
      seq_arm_reg <= 1'b0;
    end else if (flag_ev[0]) begin
      seq_arm_reg <= 1'b1;
    end else if (fire_b) begin
      seq_arm_reg <= 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      brk_req_o <= 1'b0;
      brk_pc_o  <= 32'h00000000;
    end else begin
      brk_req_o <= fire_a | fire_b;
      if (fire_a | fire_b)
        brk_pc_o <= pc_issue ? cpu_issue_pc_i : cpu_next_pc_i;
    end
  end

  always @* begin
    flag_next = flag_reg;
    if (wr_ctrl)
      flag_next = flag_reg & reg_wdata_i[`UBT_FLAG_LSB+`UBT_FLAG_W-1:`UBT_FLAG_LSB];
    flag_next = flag_next | {flag_ev[1] & ev_ibus[1], flag_ev[1] & ~ev_ibus[1],
                             flag_ev[0] & ev_ibus[0], flag_ev[0] & ~ev_ibus[0]};
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      addr_a_reg  <= 32'h00000000;
      amask_a_reg <= 32'h00000000;
      cycle_a_reg <= `UBT_RST_CYCLE;
      addr_b_reg  <= 32'h00000000;
      amask_b_reg <= 32'h00000000;
      cycle_b_reg <= `UBT_RST_CYCLE;
      data_b_reg  <= 32'h00000000;
      dmask_b_reg <= 32'h00000000;
      ctl_reg     <= `UBT_RST_CTRL;
      flag_reg    <= {`UBT_FLAG_W{1'b0}};
      cnt_reg     <= `UBT_RST_COUNT;
    end else begin
      flag_reg <= flag_next;
      if (reg_we_i) begin
        case (reg_addr_i)
          `UBT_OFS_ADDR_A:  addr_a_reg  <= reg_wdata_i;
          `UBT_OFS_AMASK_A: amask_a_reg <= reg_wdata_i;
          `UBT_OFS_CYCLE_A: cycle_a_reg <= reg_wdata_i[`UBT_CS_W-1:0];
          `UBT_OFS_ADDR_B:  addr_b_reg  <= reg_wdata_i;
          `UBT_OFS_AMASK_B: amask_b_reg <= reg_wdata_i;
          `UBT_OFS_CYCLE_B: cycle_b_reg <= reg_wdata_i[`UBT_CS_W-1:0];
          `UBT_OFS_DATA_B:  data_b_reg  <= reg_wdata_i;
          `UBT_OFS_DMASK_B: dmask_b_reg <= reg_wdata_i;
          `UBT_OFS_CTRL:    ctl_reg     <= reg_wdata_i[`UBT_CTL_W-1:0];
          `UBT_OFS_COUNT:   cnt_reg     <= reg_wdata_i[`UBT_CNT_W-1:0];
          default: ;
        endcase
      end else if (b_ok & cnt_en & ~cnt_last) begin
        cnt_reg <= cnt_reg - `UBT_CNT_W'h1;
      end
    end
  end

  always @* begin
    case (reg_addr_i)
      `UBT_OFS_ADDR_A:  rdata_next = addr_a_reg;
      `UBT_OFS_AMASK_A: rdata_next = amask_a_reg;
      `UBT_OFS_CYCLE_A: rdata_next = {24'h000000, cycle_a_reg};
      `UBT_OFS_ADDR_B:  rdata_next = addr_b_reg;
      `UBT_OFS_AMASK_B: rdata_next = amask_b_reg;
      `UBT_OFS_CYCLE_B: rdata_next = {24'h000000, cycle_b_reg};
      `UBT_OFS_DATA_B:  rdata_next = data_b_reg;
      `UBT_OFS_DMASK_B: rdata_next = dmask_b_reg;
      `UBT_OFS_CTRL:    rdata_next = {20'h00000, flag_reg, 2'h0, ctl_reg};
      `UBT_OFS_COUNT:   rdata_next = {16'h0000, cnt_reg};
      `UBT_OFS_TRC_SRC: rdata_next = {4'h0, trc_src};
      `UBT_OFS_TRC_DST: rdata_next = {4'h0, trc_dst};
      default:          rdata_next = 32'h00000000;
    endcase
  end

  always @(posedge clk_i) begin
    if (sys_rst_i)
      reg_rdata_o <= 32'h00000000;
    else if (reg_re_i)
      reg_rdata_o <= rdata_next;
    else
      reg_rdata_o <= 32'h00000000;
  end

  always @(posedge clk_i) begin
    if (sys_rst_i)
      trace_q_reg <= 1'b0;
    else
      trace_q_reg <= te;
  end

  wire trc_push = te & (cpu_br_i | cpu_exc_i);
  wire [31:0] src_full = cpu_exc_i ? cpu_exc_ret_i : cpu_br_pc_i;
  wire [31:0] dst_full = cpu_exc_i ? cpu_exc_vec_i : cpu_br_dst_i;
  wire trc_pop = reg_re_i & (reg_addr_i == `UBT_OFS_TRC_DST);

  ubt_trace_q u_trace (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .clr_i     (te & ~trace_q_reg),
    .push_i    (trc_push),
    .src_i     (src_full[`UBT_TRC_AW-1:0]),
    .dst_i     (dst_full[`UBT_TRC_AW-1:0]),
    .pop_i     (trc_pop),
    .src_o     (trc_src),
    .dst_o     (trc_dst)
  );

endmodule // ubt_break

// File: ubt_break_chk.sv
// Checker of break request timing, saved counter and read-data window.
module ubt_break_chk (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // Register port
  input  wire logic        reg_re_i,
  input  wire logic [31:0] reg_rdata_o,
  // Pipeline progress and branch trace events
  input  wire logic        cpu_issue_i,
  input  wire logic [31:0] cpu_issue_pc_i,
  input  wire logic        cpu_done_i,
  input  wire logic [31:0] cpu_next_pc_i,
  input  wire logic        cpu_reexec_exc_i,
  input  wire logic        cpu_trap_exc_i,
  input  wire logic        cpu_addr_err_i,
  input  wire logic        cpu_br_i,
  input  wire logic        cpu_exc_i,
  // Break request
  input  wire logic        brk_req_o,
  input  wire logic [31:0] brk_pc_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_done_only;
    cpu_done_i && !cpu_issue_i;
  endsequence
  sequence s_issue_only;
    cpu_issue_i && !cpu_done_i;
  endsequence
  property p_after_pc;
    s_done_only |=> (brk_req_o |-> brk_pc_o == $past(cpu_next_pc_i));
  endproperty
  property p_before_pc;
    s_issue_only |=> (brk_req_o |-> brk_pc_o == $past(cpu_issue_pc_i));
  endproperty
  property p_reexec;
    s_done_only ##0 cpu_reexec_exc_i |=> !brk_req_o;
  endproperty
  property p_completion;
    s_done_only ##0 (cpu_trap_exc_i || cpu_addr_err_i) |=> !brk_req_o;
  endproperty
  property p_cause;
    brk_req_o |-> $past(cpu_issue_i || cpu_done_i);
  endproperty
  // The reset guard keeps the clearing of the counter by reset out of the check.
  property p_pc_hold;
    !$past(sys_rst_i) && $changed(brk_pc_o) |-> brk_req_o;
  endproperty
  property p_rd_quiet;
    !reg_re_i |=> reg_rdata_o == 32'h0;
  endproperty
  property p_trace_quiet;
    (cpu_br_i || cpu_exc_i) && !cpu_issue_i && !cpu_done_i |=> !brk_req_o;
  endproperty
  a_after_pc: assert property (p_after_pc) else $error("after break counter wrong");
  a_before_pc: assert property (p_before_pc) else $error("before break counter wrong");
  a_reexec: assert property (p_reexec) else $error("break beside re-execution");
  a_completion: assert property (p_completion) else $error("break beside trap");
  a_cause: assert property (p_cause) else $error("break without instruction");
  a_pc_hold: assert property (p_pc_hold) else $error("saved counter moved");
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside window");
  a_trace_quiet: assert property (p_trace_quiet) else $error("trace event broke");
endmodule // ubt_break_chk

bind ubt_break ubt_break_chk u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_re_i(reg_re_i),
  .reg_rdata_o(reg_rdata_o), .cpu_issue_i(cpu_issue_i), .cpu_issue_pc_i(cpu_issue_pc_i),
  .cpu_done_i(cpu_done_i), .cpu_next_pc_i(cpu_next_pc_i), .cpu_reexec_exc_i(cpu_reexec_exc_i),
  .cpu_trap_exc_i(cpu_trap_exc_i), .cpu_addr_err_i(cpu_addr_err_i), .cpu_br_i(cpu_br_i),
  .cpu_exc_i(cpu_exc_i), .brk_req_o(brk_req_o), .brk_pc_o(brk_pc_o));

// File: ubt_cpu_model.sv
// Behavioural CPU core: bus cycles, instruction progress and trace events.
module ubt_cpu_model (
  // Clock
  input  wire logic        clk_i,
  // Bus cycles, address and data shared by both buses
  output logic             lbus_valid_o,
  output logic             ibus_valid_o,
  output logic [31:0]      addr_o,
  output logic             fetch_o,
  output logic             write_o,
  output logic [1:0]       size_o,
  output logic [31:0]      data_o,
  // Pipeline progress
  output logic             issue_o,
  output logic             done_o,
  output logic [31:0]      pc_o,
  output logic             reexec_o,
  output logic             trap_o,
  output logic             aerr_o,
  // Trace events
  output logic             br_o,
  output logic             exc_o,
  output logic [31:0]      src_o,
  output logic [31:0]      dst_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {lbus_valid_o, ibus_valid_o, addr_o, fetch_o, write_o, size_o, data_o, issue_o,
           done_o, pc_o, reexec_o, trap_o, aerr_o, br_o, exc_o, src_o, dst_o} = '0;
  // Released address and data lines show the inverse pattern so stale values never look valid.
  task automatic bus(input logic ib, input logic [31:0] a, input logic f, input logic w,
                     input logic [1:0] s, input logic [31:0] d);
    @(posedge clk_i);
    lbus_valid_o <= !ib;
    ibus_valid_o <= ib;
    addr_o       <= a;
    fetch_o      <= f;
    write_o      <= w;
    size_o       <= s;
    data_o       <= d;
    @(posedge clk_i);
    {lbus_valid_o, ibus_valid_o} <= 2'h0;
    addr_o       <= ~a;
    data_o       <= ~d;
  endtask
  task automatic issue(input logic [31:0] pc);
    @(posedge clk_i);
    issue_o <= 1'b1;
    pc_o    <= pc;
    @(posedge clk_i);
    issue_o <= 1'b0;
    pc_o    <= ~pc;
  endtask
  task automatic done(input logic [31:0] npc, input logic [1:0] k);
    @(posedge clk_i);
    done_o <= 1'b1;
    pc_o   <= npc;
    {reexec_o, trap_o, aerr_o} <= {k == 2'h1, k == 2'h2, k == 2'h3};
    @(posedge clk_i);
    done_o <= 1'b0;
    pc_o   <= ~npc;
    {reexec_o, trap_o, aerr_o} <= 3'h0;
  endtask
  task automatic flow(input logic e, input logic [31:0] s, input logic [31:0] d);
    @(posedge clk_i);
    br_o  <= !e;
    exc_o <= e;
    src_o <= s;
    dst_o <= d;
    @(posedge clk_i);
    {br_o, exc_o} <= 2'h0;
    src_o <= ~s;
    dst_o <= ~d;
  endtask
endmodule // ubt_cpu_model

// File: ubt_break_tb_top.sv
// Testbench of the user break unit: register, break and trace scenarios.
`include "ubt_regs.vh"
module ubt_break_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_we_i = 1'b0;
  logic        reg_re_i = 1'b0;
  logic [31:0] reg_rdata_o, brk_pc_o, m_addr, m_data, m_pc, m_src, m_dst, last_pc;
  logic        brk_req_o, m_lv, m_iv, m_fetch, m_write, cpu_issue_i, cpu_done_i;
  logic        cpu_reexec_exc_i, cpu_trap_exc_i, cpu_addr_err_i, cpu_br_i, cpu_exc_i;
  logic [1:0]  m_size;
  int          errors = 0, comparisons = 0, nbrk = 0, ebrk = 0;
  ubt_break dut (.lbus_valid_i(m_lv), .ibus_valid_i(m_iv), .lbus_addr_i(m_addr),
    .ibus_addr_i(m_addr), .lbus_fetch_i(m_fetch), .ibus_fetch_i(m_fetch),
    .lbus_write_i(m_write), .ibus_write_i(m_write), .lbus_size_i(m_size), .ibus_size_i(m_size),
    .lbus_data_i(m_data), .ibus_data_i(m_data), .cpu_issue_pc_i(m_pc), .cpu_next_pc_i(m_pc),
    .cpu_br_pc_i(m_src), .cpu_exc_ret_i(m_src), .cpu_br_dst_i(m_dst), .cpu_exc_vec_i(m_dst), .*);
  ubt_cpu_model cpu (.clk_i(clk_i), .lbus_valid_o(m_lv), .ibus_valid_o(m_iv), .addr_o(m_addr),
    .fetch_o(m_fetch), .write_o(m_write), .size_o(m_size), .data_o(m_data), .issue_o(cpu_issue_i),
    .done_o(cpu_done_i), .pc_o(m_pc), .reexec_o(cpu_reexec_exc_i), .trap_o(cpu_trap_exc_i),
    .aerr_o(cpu_addr_err_i), .br_o(cpu_br_i), .exc_o(cpu_exc_i), .src_o(m_src), .dst_o(m_dst));
  initial forever #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (brk_req_o === 1'b1) begin
      nbrk    <= nbrk + 1;
      last_pc <= brk_pc_o;
    end
  end
  task automatic complete_run;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_we_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clk_i);
    reg_re_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_re_i   <= 1'b0;
    #1;
    chk(n, e, reg_rdata_o);
  endtask
  task automatic cfg(input logic [7:0] b, input logic [31:0] a, input logic [31:0] m,
                     input logic [7:0] c);
    wr(b, a);
    wr(b + 8'h04, m);
    wr(b + 8'h08, {24'h0, c});
  endtask
  // A break lands one cycle after its deciding edge, so three edges always suffice.
  task automatic cbrk(input int add, input logic [31:0] pc);
    repeat (3) @(posedge clk_i);
    #1;
    ebrk += add;
    chk("break count", ebrk, nbrk);
    if (add != 0)
      chk("saved counter", pc, last_pc);
  endtask
  task automatic run(input logic ib, input logic [31:0] a, input logic [31:0] n,
                     input logic [1:0] k);
    cpu.bus(ib, a, 1'b1, 1'b0, `UBT_SZ_WORD, 32'h0);
    cpu.issue(a);
    cpu.done(n, k);
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    complete_run;
  end
  initial begin
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(`UBT_OFS_CTRL, 32'h0, "control reset");
    rd(`UBT_OFS_COUNT, 32'h0, "count reset");
    wr(8'h30, 32'hffff_ffff);
    rd(8'h30, 32'h0, "unmapped");
    wr(`UBT_OFS_ADDR_A, 32'h1234_5678);
    rd(`UBT_OFS_ADDR_A, 32'h1234_5678, "readback");
    $display("test registers finished");
    cfg(`UBT_OFS_ADDR_A, 32'h404, 32'h0, 8'h15);
    wr(`UBT_OFS_CTRL, 32'h0);
    run(1'b1, 32'h404, 32'h406, 2'h0);
    cbrk(0, 32'h0);
    run(1'b0, 32'h404, 32'h406, 2'h0);
    cbrk(1, 32'h404);
    rd(`UBT_OFS_CTRL, 32'h100, "flag set");
    wr(`UBT_OFS_CTRL, 32'h0);
    rd(`UBT_OFS_CTRL, 32'h0, "flag cleared");
    cfg(`UBT_OFS_ADDR_A, 32'h8404, 32'hfff, 8'h15);
    wr(`UBT_OFS_CTRL, 32'h8);
    run(1'b0, 32'h8ffe, 32'h9000, 2'h0);
    cbrk(1, 32'h9000);
    run(1'b0, 32'h9000, 32'h9002, 2'h0);
    cbrk(0, 32'h0);
    for (int k = 1; k < 4; k++) begin
      wr(`UBT_OFS_CTRL, 32'h8);
      run(1'b0, 32'h8400, 32'h8402, k[1:0]);
      cbrk(0, 32'h0);
      rd(`UBT_OFS_CTRL, (k == 1) ? 32'h8 : 32'h108, "exception flag");
    end
    run(1'b0, 32'h8400, 32'h8402, 2'h0);
    cbrk(1, 32'h8402);
    $display("test fetch breaks finished");
    cfg(`UBT_OFS_ADDR_A, 32'h27128, 32'h0, 8'ha5);
    cfg(`UBT_OFS_ADDR_B, 32'h31415, 32'h0, 8'h15);
    wr(`UBT_OFS_CTRL, 32'h0);
    run(1'b0, 32'h27128, 32'h2712a, 2'h0);
    run(1'b0, 32'h31414, 32'h31416, 2'h0);
    cbrk(0, 32'h0);
    rd(`UBT_OFS_CTRL, 32'h0, "no match flag");
    cfg(`UBT_OFS_ADDR_B, 32'h55555, 32'h0, 8'h6a);
    wr(`UBT_OFS_DATA_B, 32'h7878);
    wr(`UBT_OFS_DMASK_B, 32'h0f0f);
    wr(`UBT_OFS_CTRL, 32'h20);
    cpu.bus(1'b1, 32'h55555, 1'b0, 1'b1, `UBT_SZ_BYTE, 32'h68);
    cpu.done(32'h2002, 2'h0);
    cbrk(0, 32'h0);
    cpu.bus(1'b1, 32'h55555, 1'b0, 1'b1, `UBT_SZ_BYTE, 32'h7a);
    cpu.done(32'h2004, 2'h0);
    cbrk(1, 32'h2004);
    rd(`UBT_OFS_CTRL, 32'h820, "data flag");
    $display("test data break finished");
    cfg(`UBT_OFS_ADDR_A, 32'h37226, 32'h0, 8'h95);
    cfg(`UBT_OFS_ADDR_B, 32'h37226, 32'h0, 8'h95);
    wr(`UBT_OFS_CTRL, 32'h2);
    run(1'b0, 32'h37226, 32'h37228, 2'h0);
    cbrk(0, 32'h0);
    cfg(`UBT_OFS_ADDR_B, 32'h3722e, 32'h0, 8'h95);
    wr(`UBT_OFS_CTRL, 32'h0);
    wr(`UBT_OFS_CTRL, 32'h12);
    run(1'b0, 32'h3722e, 32'h37230, 2'h0);
    run(1'b0, 32'h37226, 32'h37228, 2'h0);
    cbrk(0, 32'h0);
    run(1'b0, 32'h3722e, 32'h37230, 2'h0);
    cbrk(1, 32'h37230);
    cfg(`UBT_OFS_ADDR_A, 32'h0, 32'h0, 8'h00);
    cfg(`UBT_OFS_ADDR_B, 32'h1000, 32'h0, 8'h15);
    wr(`UBT_OFS_COUNT, 32'h5);
    wr(`UBT_OFS_CTRL, 32'h1);
    for (int i = 1; i < 6; i++) begin
      run(1'b0, 32'h1000, 32'h1002, 2'h0);
      cbrk((i == 5) ? 1 : 0, 32'h1000);
    end
    rd(`UBT_OFS_COUNT, 32'h1, "count floor");
    cfg(`UBT_OFS_ADDR_A, 32'h500, 32'h0, 8'h15);
    cfg(`UBT_OFS_ADDR_B, 32'h500, 32'h0, 8'h15);
    wr(`UBT_OFS_CTRL, 32'h0);
    run(1'b0, 32'h500, 32'h502, 2'h0);
    cbrk(1, 32'h500);
    rd(`UBT_OFS_CTRL, 32'h500, "both flags");
    $display("test sequence count finished");
    wr(`UBT_OFS_CTRL, 32'h4);
    for (int i = 0; i < 5; i++)
      cpu.flow(i[0], 32'hf000_0000 | (i << 8), 32'h1000 + i);
    for (int i = 1; i < 5; i++) begin
      rd(`UBT_OFS_TRC_SRC, i << 8, "trace source");
      rd(`UBT_OFS_TRC_SRC, i << 8, "source kept");
      rd(`UBT_OFS_TRC_DST, 32'h1000 + i, "trace destination");
    end
    rd(`UBT_OFS_TRC_DST, 32'h0, "trace empty");
    cpu.flow(1'b0, 32'h700, 32'h800);
    wr(`UBT_OFS_CTRL, 32'h0);
    cpu.flow(1'b0, 32'h500, 32'h600);
    wr(`UBT_OFS_CTRL, 32'h4);
    rd(`UBT_OFS_TRC_SRC, 32'h0, "trace invalid");
    $display("test trace finished");
    complete_run;
  end
endmodule // ubt_break_tb_top
